// ---- logic/sadc_pkg.sv ----
// Shared constants and types of the converter control block.
package sadc_pkg;

  // ==========================================================================
  // Clocks and timing
  localparam int unsigned SYS_CLK_HZ       = 200_000_000;
  localparam int unsigned SYS_CLK_PERIOD_PS = 1_000_000_000 / (SYS_CLK_HZ / 1000);
  localparam int unsigned OSC_NOM_HZ       = 4_000_000;
  localparam int unsigned OSC_TOL_PCT      = 10;
  localparam int unsigned OSC_DIV_CYCLES   = SYS_CLK_HZ / OSC_NOM_HZ;
  localparam int unsigned CONV_TIME_MAX_NS = 3700;
  localparam int unsigned CONV_MAX_CYCLES  = (CONV_TIME_MAX_NS * 1000) / SYS_CLK_PERIOD_PS;

  // ==========================================================================
  // Result format
  localparam int unsigned RESULT_BITS = 12;

  // ==========================================================================
  // Control states
  typedef enum logic [1:0]
  {
    ST_SHUTDOWN = 2'b00,
    ST_TRACK    = 2'b01,
    ST_CONVERT  = 2'b10,
    ST_READOUT  = 2'b11
  } sadc_state_t;

endpackage

// ---- logic/sadc_sync.sv ----
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module sadc_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             arst_n_in,
  // Levels
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stage_one <= '0;
      q_out     <= '0;
    end
    else
    begin
      stage_one <= d_in;
      q_out     <= stage_one;
    end
  end

endmodule

// ---- logic/sadc_sar.sv ----
// Successive approximation engine: one trial bit per oscillator tick.
`timescale 1ns/1ps
module sadc_sar
#(
  parameter int unsigned BITS = 12
)
(
  // Clock and reset
  input  wire logic            clk_sys_in,
  input  wire logic            arst_n_in,
  // Control
  input  wire logic            start_in,
  input  wire logic            abort_in,
  input  wire logic            tick_in,
  input  wire logic            cmp_high_in,
  // Results
  output logic      [BITS-1:0] trial_out,
  output logic      [BITS-1:0] result_out,
  output logic                 done_out
);

  logic [BITS-1:0] probe;
  logic [BITS-1:0] kept;

  // The comparator says whether the input stands above the trial code.
  assign kept = cmp_high_in ? trial_out : (trial_out & ~probe);

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      trial_out  <= '0;
      result_out <= '0;
      probe      <= '0;
      done_out   <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (abort_in)
      begin
        probe <= '0;
      end
      else if (start_in)
      begin
        probe     <= {1'b1, {(BITS-1){1'b0}}};
        trial_out <= {1'b1, {(BITS-1){1'b0}}};
      end
      else if (tick_in && (probe != '0))
      begin
        probe     <= probe >> 1;
        trial_out <= kept | (probe >> 1);
        if (probe[0])
        begin
          result_out <= kept;
          done_out   <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- logic/sadc_top.sv ----
// Conversion control and serial readout of the successive approximation converter.
`timescale 1ns/1ps
module sadc_top
#(
  parameter bit          DIFFERENTIAL = 1'b0,
  parameter int unsigned RES_BITS     = sadc_pkg::RESULT_BITS,
  parameter int unsigned OSC_DIV      = sadc_pkg::OSC_DIV_CYCLES
)
(
  // System clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                arst_n_in,
  // Host pins
  input  wire logic                serial_clock_in,
  input  wire logic                conversion_start_line_in,
  output logic                     data_out,
  output logic                     data_oe_n_out,
  // Analog front end
  input  wire logic                comparator_high_in,
  output logic      [RES_BITS-1:0] dac_code_out,
  output logic                     track_out,
  output logic                     power_down_out,
  output logic                     channel_two_select_out,
  output logic                     bipolar_mode_out
);

  import sadc_pkg::*;

  localparam int unsigned CNT_W = $clog2(RES_BITS + 1);
  localparam int unsigned OSC_W = $clog2(OSC_DIV);
  localparam logic [CNT_W-1:0] BITS_FULL = CNT_W'(RES_BITS);
  localparam logic [OSC_W-1:0] OSC_LAST  = OSC_W'(OSC_DIV - 1);

  // ==========================================================================
  // Link domain
  // Each read clock edge flips a toggle; the system side sees the flips as
  // events. The read clock may stop at any time, so nothing here waits on it.
  logic link_rise_toggle;
  logic link_fall_toggle;

  always_ff @(posedge serial_clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      link_rise_toggle <= 1'b0;
    else
      link_rise_toggle <= ~link_rise_toggle;
  end

  always_ff @(negedge serial_clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      link_fall_toggle <= 1'b0;
    else
      link_fall_toggle <= ~link_fall_toggle;
  end

  // ==========================================================================
  // Input synchronisation and edge detection
  logic [3:0] sync_bus;
  logic       start_sync;
  logic       cmp_sync;
  logic       rise_sync;
  logic       fall_sync;
  logic       start_prev;
  logic       rise_prev;
  logic       fall_prev;
  logic       cs_rise;
  logic       cs_fall;
  logic       rise_evt;
  logic       fall_evt;

  sadc_sync #(.WIDTH(4)) u_sync
  (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .d_in       ({conversion_start_line_in, comparator_high_in,
                  link_rise_toggle, link_fall_toggle}),
    .q_out      (sync_bus)
  );

  assign {start_sync, cmp_sync, rise_sync, fall_sync} = sync_bus;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      start_prev <= 1'b0;
      rise_prev  <= 1'b0;
      fall_prev  <= 1'b0;
    end
    else
    begin
      start_prev <= start_sync;
      rise_prev  <= rise_sync;
      fall_prev  <= fall_sync;
    end
  end

  assign cs_rise  = start_sync & ~start_prev;
  assign cs_fall  = ~start_sync & start_prev;
  assign rise_evt = rise_sync ^ rise_prev;
  assign fall_evt = fall_sync ^ fall_prev;

  // ==========================================================================
  // Internal conversion oscillator
  sadc_state_t      state;
  logic [OSC_W-1:0] osc_count;
  logic             osc_tick;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      osc_count <= '0;
    else if ((state != ST_CONVERT) || osc_tick)
      osc_count <= '0;
    else
      osc_count <= osc_count + 1'b1;
  end

  assign osc_tick = (state == ST_CONVERT) && (osc_count == OSC_LAST);

  // ==========================================================================
  // Successive approximation engine
  logic                conv_begin;
  logic                conv_abort;
  logic                sar_done;
  logic [RES_BITS-1:0] sar_result;
  logic [RES_BITS-1:0] fmt_word;
  logic                alt_select;

  assign conv_begin = (state == ST_TRACK) && cs_fall;
  assign conv_abort = (state == ST_CONVERT) && cs_rise;

  sadc_sar #(.BITS(RES_BITS)) u_sar
  (
    .clk_sys_in  (clk_sys_in),
    .arst_n_in   (arst_n_in),
    .start_in    (conv_begin),
    .abort_in    (conv_abort),
    .tick_in     (osc_tick),
    .cmp_high_in (cmp_sync),
    .trial_out   (dac_code_out),
    .result_out  (sar_result),
    .done_out    (sar_done)
  );

  // The engine yields offset binary; flipping the top bit gives two's complement.
  assign fmt_word = (DIFFERENTIAL && alt_select)
                  ? {~sar_result[RES_BITS-1], sar_result[RES_BITS-2:0]}
                  : sar_result;

  // ==========================================================================
  // Control state machine
  logic [CNT_W-1:0] rises_seen;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state          <= ST_SHUTDOWN;
      track_out      <= 1'b0;
      power_down_out <= 1'b1;
      alt_select     <= 1'b0;
    end
    else
    begin
      case (state)
        ST_SHUTDOWN:
        begin
          if (cs_rise)
          begin
            state          <= ST_TRACK;
            track_out      <= 1'b1;
            power_down_out <= 1'b0;
            alt_select     <= 1'b0;
          end
        end
        ST_TRACK:
        begin
          if (cs_fall)
          begin
            state     <= ST_CONVERT;
            track_out <= 1'b0;
          end
        end
        ST_CONVERT:
        begin
          if (cs_rise)
          begin
            // A second rise inside the pulse pair lands here.
            state      <= ST_TRACK;
            track_out  <= 1'b1;
            alt_select <= 1'b1;
          end
          else if (sar_done)
          begin
            state          <= ST_READOUT;
            power_down_out <= 1'b1;
          end
        end
        ST_READOUT:
        begin
          if (cs_rise)
          begin
            state          <= ST_TRACK;
            track_out      <= 1'b1;
            power_down_out <= 1'b0;
            alt_select     <= 1'b1;
          end
          else if (rises_seen == BITS_FULL)
          begin
            state <= ST_SHUTDOWN;
          end
        end
        default:
        begin
          state          <= ST_SHUTDOWN;
          track_out      <= 1'b0;
          power_down_out <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      channel_two_select_out <= 1'b0;
      bipolar_mode_out       <= 1'b0;
    end
    else
    begin
      channel_two_select_out <= !DIFFERENTIAL && alt_select;
      bipolar_mode_out       <= DIFFERENTIAL && alt_select;
    end
  end

  // ==========================================================================
  // Serial readout
  // A fall before the first rise is ignored so that an idle-high clock cannot
  // skip the top bit before the host has sampled it.
  logic [RES_BITS-1:0] shift;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shift         <= '0;
      rises_seen    <= '0;
      data_out      <= 1'b0;
      data_oe_n_out <= 1'b1;
    end
    else if (cs_rise)
    begin
      rises_seen    <= '0;
      data_out      <= 1'b0;
      data_oe_n_out <= 1'b0;
    end
    else if ((state == ST_CONVERT) && sar_done)
    begin
      shift    <= fmt_word;
      data_out <= fmt_word[RES_BITS-1];
    end
    else if ((state == ST_READOUT) && !data_oe_n_out)
    begin
      if (fall_evt && (rises_seen != '0))
      begin
        shift    <= shift << 1;
        data_out <= shift[RES_BITS-2];
      end
      if (rise_evt)
      begin
        rises_seen <= rises_seen + 1'b1;
        if (rises_seen == BITS_FULL - 1'b1)
          data_oe_n_out <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Checks
  logic [15:0] conv_cycles;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      conv_cycles <= '0;
    else if (state != ST_CONVERT)
      conv_cycles <= '0;
    else
      conv_cycles <= conv_cycles + 1'b1;
  end

  sequence s_idle_rise;
    (state == ST_SHUTDOWN) && cs_rise;
  endsequence

  sequence s_conv_done;
    (state == ST_CONVERT) && sar_done && !cs_rise;
  endsequence

  property p_power_up;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_idle_rise |=> (state == ST_TRACK) && track_out && !power_down_out;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("Start rise did not power up into track.");

  property p_hold;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == ST_TRACK) && cs_fall |=> (state == ST_CONVERT) && !track_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Start fall did not enter hold and convert.");

  property p_start_low;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    cs_rise |=> !data_out && !data_oe_n_out;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("Data line not driven low at start.");

  property p_msb_out;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_conv_done |=> (data_out == $past(fmt_word[RES_BITS-1])) && !data_oe_n_out
                    && power_down_out;
  endproperty
  a_msb_out: assert property (p_msb_out)
    else $error("Top bit not shown at conversion end.");

  property p_change_cause;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    $changed(data_out) |-> $past(fall_evt) || $past(sar_done) || $past(cs_rise);
  endproperty
  a_change_cause: assert property (p_change_cause)
    else $error("Data line changed without a read clock fall.");

  property p_shift;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == ST_READOUT) && !data_oe_n_out && fall_evt && (rises_seen != '0) && !cs_rise
      |=> data_out == $past(shift[RES_BITS-2]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("Next result bit not shifted out.");

  property p_float;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (state == ST_READOUT) && !data_oe_n_out && rise_evt && !cs_rise
      && (rises_seen == BITS_FULL - 1'b1) |=> data_oe_n_out ##1 (state == ST_SHUTDOWN);
  endproperty
  a_float: assert property (p_float)
    else $error("Data line not released after last bit.");

  property p_conv_time;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    conv_cycles <= 16'(CONV_MAX_CYCLES);
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("Conversion ran longer than allowed.");

  property p_alt_pick;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ((state == ST_READOUT) || (state == ST_CONVERT)) && cs_rise
      |=> alt_select ##1 (channel_two_select_out != bipolar_mode_out);
  endproperty
  a_alt_pick: assert property (p_alt_pick)
    else $error("Early start rise did not pick the second selection.");

  property p_first_pick;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_idle_rise |=> !alt_select ##1 (!channel_two_select_out && !bipolar_mode_out);
  endproperty
  a_first_pick: assert property (p_first_pick)
    else $error("Single rise did not pick the first selection.");

endmodule

// ---- test/sadc_host.sv ----
// Host model: drives the start line and the serial read clock, captures result bits.
`timescale 1ns/1ps
module sadc_host
#(
  parameter int unsigned ACQ_CYCLES   = 280,
  parameter int unsigned PULSE_CYCLES = 8,
  parameter int unsigned HALF_TICKS   = 11
)
(
  // System clock paces the start line
  input  wire logic clk_sys_in,
  // Host pins
  input  wire logic data_pin_in,
  output logic      conversion_start_line_out,
  output logic      serial_clock_out
);
  logic base_clk;

  // ==========================================================================
  // Read clock time base
  // A 6 ns base that is unrelated in phase to the system clock; the read clock
  // is built from it and stands still at low outside reads.
  initial
  begin
    base_clk = 1'b0;
    #1.7;
    forever #3 base_clk = ~base_clk;
  end

  initial
  begin
    conversion_start_line_out = 1'b0;
    serial_clock_out = 1'b0;
  end

  // ==========================================================================
  // Start line
  task automatic rise(input bit pair);
    @(negedge clk_sys_in) conversion_start_line_out <= 1'b1;
    if (pair)
    begin
      repeat (PULSE_CYCLES) @(negedge clk_sys_in);
      conversion_start_line_out <= 1'b0;
      repeat (PULSE_CYCLES) @(negedge clk_sys_in);
      conversion_start_line_out <= 1'b1;
    end
  endtask

  task automatic fall();
    repeat (ACQ_CYCLES) @(negedge clk_sys_in);
    conversion_start_line_out <= 1'b0;
  endtask

  // ==========================================================================
  // Serial read, bits taken at the rising read clock edge
  task automatic read(input int n, output logic [11:0] word);
    word = 12'h000;
    for (int i = 0; i < n; i++)
    begin
      repeat (HALF_TICKS) @(posedge base_clk);
      serial_clock_out = 1'b1;
      word = {word[10:0], data_pin_in};
      repeat (HALF_TICKS) @(posedge base_clk);
      serial_clock_out = 1'b0;
    end
  endtask
endmodule

// ---- test/sadc_top_tb.sv ----
// Self-checking bench of the converter control block in both builds.
`timescale 1ns/1ps
module sadc_top_tb;
  import sadc_pkg::*;

  typedef struct packed {bit diff; bit sel; bit [11:0] ain; bit [11:0] res;} sadc_row_t;
  localparam sadc_row_t ROWS [8] = '{
    '{0, 0, 12'hfff, 12'hfff}, '{0, 1, 12'h000, 12'h000}, '{0, 0, 12'ha5c, 12'ha5c},
    '{0, 1, 12'h7ff, 12'h7ff}, '{1, 0, 12'h800, 12'h800}, '{1, 1, 12'h800, 12'h000},
    '{1, 1, 12'h3c1, 12'hbc1}, '{1, 0, 12'h001, 12'h001}};

  logic        clk_sys;
  logic        arst_n = 1'b0;
  logic [11:0] ain [2] = '{12'h000, 12'h000};
  wire         cs [2], sck [2], dat [2], oen [2], trk [2], pd [2], ch2 [2], bip [2];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  // ==========================================================================
  // Both builds, each with its own host and analog model
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_dut
    logic        cmp = 1'b0;
    logic        last = 1'b0;
    wire  [11:0] dac;
    wire         pin;
    // A released pin shows the inverse of its last level, never a stale copy.
    assign pin = oen[gi] ? ~last : dat[gi];
    always @(posedge clk_sys) if (oen[gi] === 1'b0) last <= dat[gi];
    // The input sits half a step above ain, so an equal trial code is kept.
    always @(negedge clk_sys) cmp <= (ain[gi] >= dac);
    sadc_top #(.DIFFERENTIAL(gi == 1)) sadc_top_inst (
      .clk_sys_in(clk_sys), .arst_n_in(arst_n), .serial_clock_in(sck[gi]),
      .conversion_start_line_in(cs[gi]), .data_out(dat[gi]), .data_oe_n_out(oen[gi]),
      .comparator_high_in(cmp), .dac_code_out(dac), .track_out(trk[gi]),
      .power_down_out(pd[gi]), .channel_two_select_out(ch2[gi]),
      .bipolar_mode_out(bip[gi]));
    sadc_host sadc_host_inst (.clk_sys_in(clk_sys), .data_pin_in(pin),
      .conversion_start_line_out(cs[gi]), .serial_clock_out(sck[gi]));
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Compare, report and helper tasks
  task automatic tally_and_finish();
    $display("errors %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_word(input string name, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic h_rise(input int g, input bit pair);
    if (g == 1) g_dut[1].sadc_host_inst.rise(pair);
    else g_dut[0].sadc_host_inst.rise(pair);
  endtask

  task automatic h_read(input int g, input int n, output logic [11:0] w);
    if (g == 1) g_dut[1].sadc_host_inst.read(n, w);
    else g_dut[0].sadc_host_inst.read(n, w);
  endtask

  task automatic check_track(input int g, input logic sel);
    repeat (10) @(negedge clk_sys);
    check_bit("track", 1'b1, trk[g]);
    check_bit("awake", 1'b0, pd[g]);
    check_bit("low_at_start", 1'b0, dat[g]);
    check_bit("driven_at_start", 1'b0, oen[g]);
    check_bit("ch2", (g == 0) & sel, ch2[g]);
    check_bit("bip", (g == 1) & sel, bip[g]);
  endtask

  task automatic do_conv(input int g, input logic msb);
    int k;
    if (g == 1) g_dut[1].sadc_host_inst.fall();
    else g_dut[0].sadc_host_inst.fall();
    for (k = 0; k < 740 && pd[g] !== 1'b1; k++) @(negedge clk_sys);
    check_bit("done_in_time", 1'b1, pd[g]);
    check_bit("hold", 1'b0, trk[g]);
    check_bit("msb", msb, dat[g]);
    check_bit("driven_at_done", 1'b0, oen[g]);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [11:0] w;
    int          g;
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (100) @(negedge clk_sys);
    for (g = 0; g < 2; g++)
    begin
      check_bit("idle_pd", 1'b1, pd[g]);
      check_bit("idle_float", 1'b1, oen[g]);
    end
    foreach (ROWS[i])
    begin
      g = ROWS[i].diff;
      ain[g] = ROWS[i].ain;
      h_rise(g, ROWS[i].sel);
      check_track(g, ROWS[i].sel);
      do_conv(g, ROWS[i].res[11]);
      h_read(g, 12, w);
      check_word("result", ROWS[i].res, w);
      repeat (10) @(negedge clk_sys);
      check_bit("float", 1'b1, oen[g]);
      h_read(g, 2, w);
      check_bit("float_extra", 1'b1, oen[g]);
      check_bit("shutdown", 1'b1, pd[g]);
    end
    // A rise in mid-readout picks the second selection for the next conversion.
    for (g = 0; g < 2; g++)
    begin
      ain[g] = 12'h5a3;
      h_rise(g, 1'b0);
      check_track(g, 1'b0);
      do_conv(g, 1'b0);
      h_read(g, 6, w);
      h_rise(g, 1'b0);
      check_track(g, 1'b1);
      do_conv(g, g == 1);
      h_read(g, 12, w);
      check_word("after_partial", g ? 12'hda3 : 12'h5a3, w);
    end
    // A rise in mid-conversion aborts it and selects input two.
    h_rise(0, 1'b0);
    check_track(0, 1'b0);
    g_dut[0].sadc_host_inst.fall();
    repeat (100) @(negedge clk_sys);
    h_rise(0, 1'b0);
    check_track(0, 1'b1);
    do_conv(0, 1'b0);
    h_read(0, 12, w);
    check_word("after_abort", 12'h5a3, w);
    // Reset in mid-readout floats the pin and powers the converter down.
    h_rise(0, 1'b0);
    check_track(0, 1'b0);
    do_conv(0, 1'b0);
    h_read(0, 5, w);
    @(negedge clk_sys);
    arst_n = 1'b0;
    #1;
    check_bit("reset_float", 1'b1, oen[0]);
    check_bit("reset_pd", 1'b1, pd[0]);
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    h_rise(0, 1'b0);
    check_track(0, 1'b0);
    do_conv(0, 1'b0);
    h_read(0, 12, w);
    check_word("after_reset", 12'h5a3, w);
    tally_and_finish();
  end
endmodule
